// *** rtl/bit_string_unit.sv ***
// Bit chain shifter, byte swap and string engine over a private data memory
`timescale 1ns/1ps
// Overview of operation
// - Each shift moves whole chain one position
// - Chain is start bit plus signed length
// - Negative length inserts high, overflow from low
// - Positive length inserts low, overflow from high
// - Highest bit found by divide-by-eight arithmetic
// - Chains up to 64 bits, longer is error
// - Shift errors: indirect, range, count codes
// - Swap exchanges word bytes, indirect, range error codes
// - Length op writes character count byte
// - Copy duplicates source string with length
// - Append adds source after destination, updates length
// - Length, copy, append report indirect, range errors
// - Substring copy takes count from one-based index
// - Index must be 1..length, zero index coded
// - Substring search writes first match position
// - Substring search writes zero when absent
// - Charset search writes first matching position
// - Charset search writes zero when absent
module bit_string_unit
   import bsm_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 ce_i,
   input  wire logic                 start_i,
   input  wire op_e                  op_i,
   input  wire logic                 ind_fault_i,
   input  wire logic [MEM_AW-1:0]    addr_a_i,
   input  wire logic [MEM_AW-1:0]    addr_b_i,
   input  wire logic [MEM_AW-1:0]    addr_c_i,
   input  wire logic [BIT_IDX_W-1:0] start_bit_i,
   input  wire logic [BYTE_W-1:0]    chain_len_i,
   input  wire logic                 data_bit_i,
   input  wire logic [BYTE_W-1:0]    start_index_i,
   input  wire logic [BYTE_W-1:0]    count_i,
   input  wire logic                 ext_we_i,
   input  wire logic [MEM_AW-1:0]    ext_addr_i,
   input  wire logic [BYTE_W-1:0]    ext_wdata_i,
   output logic                      busy_o,
   output logic                      done_o,
   output logic                      enable_output_flag_o,
   output logic      [15:0]          err_code_o,
   output logic                      overflow_flag_o,
   output logic      [BYTE_W-1:0]    ext_rdata_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // State and operand registers
   state_e               state_r;
   state_e               state_nxt;
   op_e                  op_r;
   logic [MEM_AW-1:0]    a_r;
   logic [MEM_AW-1:0]    b_r;
   logic [MEM_AW-1:0]    c_r;
   logic [BIT_IDX_W-1:0] sbit_r;
   logic [BYTE_W-1:0]    nlen_r;
   logic                 dbit_r;
   logic [BYTE_W-1:0]    idx_r;
   logic [BYTE_W-1:0]    cnt_r;
   logic [BYTE_W-1:0]    len_a_r;
   logic [BYTE_W-1:0]    len_b_r;
   logic [15:0]          err_r;
   logic [MEM_AW-1:0]    cur_r;
   logic [MEM_AW-1:0]    dst_r;
   logic [MEM_AW-1:0]    end_r;
   logic [BYTE_W-1:0]    rem_r;
   logic                 carry_r;
   logic                 ovf_r;
   logic [BIT_IDX_W-1:0] mbit_r;
   logic                 fin_en_r;
   logic [MEM_AW-1:0]    fin_addr_r;
   logic [BYTE_W-1:0]    fin_data_r;
   logic [BYTE_W-1:0]    pos_r;
   logic [BYTE_W-1:0]    j_r;
   logic [8:0]           last_r;
   logic [BYTE_W-1:0]    ca_r;

   logic [BYTE_W-1:0]    mem_rdata;
   logic [BYTE_W-1:0]    step_byte;
   logic                 step_carry;

   ////////////////////////////////////////////////////////////////////////////////
   // Operation decode
   wire is_shift  = (op_r == OP_SERIAL_BIT_SHIFTER);
   wire is_swap   = (op_r == OP_BYTE_SWAP);
   wire is_string_length_op   = (op_r == OP_STRING_LENGTH);
   wire is_string_copy_op   = (op_r == OP_STRING_COPY);
   wire is_string_append_op   = (op_r == OP_STRING_APPEND);
   wire is_substring_copy_op  = (op_r == OP_SUBSTRING_COPY);
   wire is_substring_search_op   = (op_r == OP_SUBSTRING_SEARCH);
   wire is_search = is_substring_search_op || (op_r == OP_CHARSET_SEARCH);

   ////////////////////////////////////////////////////////////////////////////////
   // Bit chain location
   wire                 minus_w   = nlen_r[SIGN_BIT];
   wire [BYTE_W-1:0]    mag_w     = minus_w ? (8'h00 - nlen_r) : nlen_r;
   wire [8:0]           span_w    = {1'b0, mag_w} - 9'h001 + {6'h00, sbit_r};
   wire [8:0]           msb_adr9  = {1'b0, a_r} + {3'h0, span_w[8:3]};
   wire [BIT_IDX_W-1:0] msb_bit_w = span_w[2:0];
   wire                 cnt_bad_w = (mag_w == 8'h00) || (mag_w > CHAIN_MAX_LEN);

   wire [15:0] err_shift_w = cnt_bad_w   ? ERR_COUNT :
                             msb_adr9[8] ? ERR_RANGE : ERR_NONE;

   ////////////////////////////////////////////////////////////////////////////////
   // String range checks; the search start sits in the byte read from the output address
   wire [BYTE_W-1:0] start_w   = mem_rdata;
   wire [8:0]        a_end9    = {1'b0, a_r} + {1'b0, len_a_r};
   wire [8:0]        b_end9    = {1'b0, b_r} + {1'b0, len_b_r};
   wire [8:0]        cpy_end9  = {1'b0, b_r} + {1'b0, len_a_r};
   wire [8:0]        sum9      = {1'b0, len_a_r} + {1'b0, len_b_r};
   wire [9:0]        cat_end10 = {2'h0, b_r} + {1'b0, sum9};
   wire [8:0]        sub_last9 = {1'b0, idx_r} + {1'b0, cnt_r} - 9'h001;
   wire [8:0]        sub_dst9  = {1'b0, b_r} + {1'b0, cnt_r};
   wire              a_bad_w   = a_end9[8] || (len_a_r > STR_MAX_LEN);

   wire [15:0] err_swap_w = (a_r == ADDR_TOP) ? ERR_RANGE : ERR_NONE;
   wire [15:0] err_string_length_op_w = a_bad_w ? ERR_RANGE : ERR_NONE;
   wire [15:0] err_string_copy_op_w = (a_bad_w || cpy_end9[8]) ? ERR_RANGE : ERR_NONE;
   wire [15:0] err_string_append_op_w = (a_bad_w || (sum9 > {1'b0, STR_MAX_LEN}) ||
                             (cat_end10[9:8] != 2'h0)) ? ERR_RANGE : ERR_NONE;
   wire [15:0] err_sub_w  = (idx_r == 8'h00) ? ERR_INDEX0 :
                            (a_bad_w || (idx_r > len_a_r) || (sub_last9 > {1'b0, len_a_r}) ||
                             sub_dst9[8]) ? ERR_RANGE : ERR_NONE;
   wire [15:0] err_find_w = (start_w == 8'h00) ? ERR_INDEX0 :
                            (a_bad_w || b_end9[8] || (start_w > len_a_r) ||
                             (is_substring_search_op && (len_b_r == 8'h00))) ? ERR_RANGE : ERR_NONE;

   wire [15:0] err_chk_w = is_shift  ? err_shift_w :
                           is_swap   ? err_swap_w  :
                           is_string_length_op   ? err_string_length_op_w  :
                           is_string_copy_op   ? err_string_copy_op_w  :
                           is_string_append_op   ? err_string_append_op_w  :
                           is_substring_copy_op  ? err_sub_w   : err_find_w;
   wire        chk_ok_w  = (err_chk_w == ERR_NONE);

   // Last start position at which a match can still begin
   wire [8:0] last9_w   = is_substring_search_op ? ({1'b0, len_a_r} + 9'h001 - {1'b0, len_b_r})
                                  : {1'b0, len_a_r};
   wire       no_scan_w = (len_b_r == 8'h00) || last9_w[8] ||
                          ({1'b0, start_w} > last9_w);

   ////////////////////////////////////////////////////////////////////////////////
   // Shift and compare stepping
   wire [BIT_IDX_W-1:0] lo_w      = (cur_r == a_r)   ? sbit_r : BIT_LOW;
   wire [BIT_IDX_W-1:0] hi_w      = (cur_r == msb_adr9[7:0]) ? mbit_r : BIT_HIGH;
   wire                 sh_last_w = (cur_r == end_r);
   wire [MEM_AW-1:0]    a_char_w  = is_substring_search_op ? (a_r + pos_r + j_r - 8'h01) : (a_r + pos_r);
   wire                 match_w   = (mem_rdata == ca_r);
   wire                 j_last_w  = (j_r == len_b_r);
   wire                 pos_last_w = ({1'b0, pos_r} == last_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Memory port: outside access only while idle
   wire idle_w = (state_r == ST_IDLE);
   wire eng_we = (state_r == ST_SH_WR) || (state_r == ST_SW_WR) ||
                 (state_r == ST_CP_WR) || (state_r == ST_FIN_WR);
   wire [MEM_AW-1:0] eng_addr =
      (state_r == ST_RD_A)   ? a_r :
      (state_r == ST_RD_B)   ? (is_swap ? (a_r + 8'h01) : b_r) :
      (state_r == ST_RD_C)   ? c_r :
      (state_r == ST_SW_WR)  ? a_r :
      (state_r == ST_CP_WR)  ? dst_r :
      (state_r == ST_FIN_WR) ? fin_addr_r :
      (state_r == ST_CMP_RA) ? a_char_w :
      (state_r == ST_CMP_RB) ? (b_r + j_r) : cur_r;
   wire [BYTE_W-1:0] eng_wdata =
      (state_r == ST_SH_WR)  ? step_byte :
      (state_r == ST_SW_WR)  ? len_b_r :
      (state_r == ST_CP_WR)  ? mem_rdata : fin_data_r;

   wire              mem_we    = idle_w ? ext_we_i    : eng_we;
   wire [MEM_AW-1:0] mem_addr  = idle_w ? ext_addr_i  : eng_addr;
   wire [BYTE_W-1:0] mem_wdata = idle_w ? ext_wdata_i : eng_wdata;

   data_mem u_mem (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .we_i      (mem_we),
      .addr_i    (mem_addr),
      .wdata_i   (mem_wdata),
      .rdata_o   (mem_rdata)
   );

   bit_chain_step u_step (
      .byte_i  (mem_rdata),
      .lo_i    (lo_w),
      .hi_i    (hi_w),
      .minus_i (minus_w),
      .carry_i (carry_r),
      .byte_o  (step_byte),
      .carry_o (step_carry)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:   state_nxt = start_i ? (ind_fault_i ? ST_DONE : ST_RD_A) : ST_IDLE;
         ST_RD_A:   state_nxt = ST_RD_B;
         ST_RD_B:   state_nxt = ST_RD_C;
         ST_RD_C:   state_nxt = ST_CHECK;
         ST_CHECK: begin
            if (!chk_ok_w) begin
               state_nxt = ST_DONE;
            end else if (is_shift) begin
               state_nxt = ST_SH_RD;
            end else if (is_swap) begin
               state_nxt = ST_SW_WR;
            end else if (is_string_length_op) begin
               state_nxt = ST_FIN_WR;
            end else if (is_string_copy_op) begin
               state_nxt = ST_CP_RD;
            end else if (is_string_append_op) begin
               state_nxt = (len_a_r == 8'h00) ? ST_FIN_WR : ST_CP_RD;
            end else if (is_substring_copy_op) begin
               state_nxt = (cnt_r == 8'h00) ? ST_FIN_WR : ST_CP_RD;
            end else begin
               state_nxt = no_scan_w ? ST_FIN_WR : ST_CMP_RA;
            end
         end
         ST_SH_RD:  state_nxt = ST_SH_WR;
         ST_SH_WR:  state_nxt = sh_last_w ? ST_DONE : ST_SH_RD;
         ST_SW_WR:  state_nxt = ST_FIN_WR;
         ST_CP_RD:  state_nxt = ST_CP_WR;
         ST_CP_WR:  state_nxt = (rem_r == 8'h01) ? (fin_en_r ? ST_FIN_WR : ST_DONE) : ST_CP_RD;
         ST_FIN_WR: state_nxt = ST_DONE;
         ST_CMP_RA: state_nxt = ST_CMP_RB;
         ST_CMP_RB: state_nxt = ST_CMP_EV;
         ST_CMP_EV: begin
            if (is_substring_search_op) begin
               state_nxt = ((match_w && j_last_w) || (!match_w && pos_last_w)) ?
                           ST_FIN_WR : ST_CMP_RA;
            end else begin
               state_nxt = (match_w || (j_last_w && pos_last_w)) ? ST_FIN_WR : ST_CMP_RA;
            end
         end
         ST_DONE:   state_nxt = ST_IDLE;
         // A corrupted one-hot code falls back to idle
         default:   state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operand capture
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         op_r   <= OP_SERIAL_BIT_SHIFTER;
         a_r    <= 8'h00;
         b_r    <= 8'h00;
         c_r    <= 8'h00;
         sbit_r <= 3'h0;
         nlen_r <= 8'h00;
         dbit_r <= 1'b0;
         idx_r  <= 8'h00;
         cnt_r  <= 8'h00;
      end else if (ce_i && idle_w && start_i) begin
         op_r   <= op_i;
         a_r    <= addr_a_i;
         b_r    <= addr_b_i;
         c_r    <= addr_c_i;
         sbit_r <= start_bit_i;
         nlen_r <= chain_len_i;
         dbit_r <= data_bit_i;
         idx_r  <= start_index_i;
         cnt_r  <= count_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Working registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         len_a_r <= 8'h00;
         len_b_r <= 8'h00;
         err_r   <= ERR_NONE;
         cur_r   <= 8'h00;
         dst_r   <= 8'h00;
         end_r   <= 8'h00;
         rem_r   <= 8'h00;
         carry_r <= 1'b0;
         ovf_r   <= 1'b0;
         mbit_r  <= 3'h0;
         fin_en_r   <= 1'b0;
         fin_addr_r <= 8'h00;
         fin_data_r <= 8'h00;
         pos_r   <= 8'h00;
         j_r     <= 8'h00;
         last_r  <= 9'h000;
         ca_r    <= 8'h00;
      end else if (ce_i) begin
         case (state_r)
            ST_IDLE: begin
               err_r <= ind_fault_i ? ERR_INDIRECT : ERR_NONE;
            end
            ST_RD_B:  len_a_r <= mem_rdata;
            ST_RD_C:  len_b_r <= mem_rdata;
            ST_CHECK: begin
               err_r      <= err_chk_w;
               carry_r    <= dbit_r;
               mbit_r     <= msb_bit_w;
               cur_r      <= minus_w ? msb_adr9[7:0] : a_r;
               end_r      <= minus_w ? a_r : msb_adr9[7:0];
               fin_en_r   <= !is_string_copy_op;
               fin_addr_r <= is_swap ? (a_r + 8'h01) : is_search ? c_r : b_r;
               fin_data_r <= is_swap   ? len_a_r :
                             is_string_length_op   ? len_a_r :
                             is_string_append_op   ? sum9[7:0] :
                             is_substring_copy_op  ? cnt_r : 8'h00;
               if (is_string_copy_op) begin
                  cur_r <= a_r;
                  dst_r <= b_r;
                  rem_r <= len_a_r + 8'h01;
               end else if (is_string_append_op) begin
                  cur_r <= a_r + 8'h01;
                  dst_r <= b_r + len_b_r + 8'h01;
                  rem_r <= len_a_r;
               end else if (is_substring_copy_op) begin
                  cur_r <= a_r + idx_r;
                  dst_r <= b_r + 8'h01;
                  rem_r <= cnt_r;
               end
               pos_r  <= start_w;
               j_r    <= FIRST_INDEX;
               last_r <= last9_w;
            end
            ST_SH_WR: begin
               carry_r <= step_carry;
               cur_r   <= minus_w ? (cur_r - 8'h01) : (cur_r + 8'h01);
               if (sh_last_w) begin
                  ovf_r <= step_carry;
               end
            end
            ST_CP_WR: begin
               cur_r <= cur_r + 8'h01;
               dst_r <= dst_r + 8'h01;
               rem_r <= rem_r - 8'h01;
            end
            ST_CMP_RB: ca_r <= mem_rdata;
            ST_CMP_EV: begin
               if (match_w && (!is_substring_search_op || j_last_w)) begin
                  fin_data_r <= pos_r;
               end else if (match_w || (!is_substring_search_op && !j_last_w)) begin
                  j_r <= j_r + 8'h01;
               end else begin
                  pos_r <= pos_r + 8'h01;
                  j_r   <= FIRST_INDEX;
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Completion outputs; overflow only moves on a successful shift
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         busy_o               <= 1'b0;
         done_o               <= 1'b0;
         enable_output_flag_o <= 1'b1;
         err_code_o           <= ERR_NONE;
         overflow_flag_o      <= 1'b0;
      end else if (ce_i) begin
         busy_o <= (state_nxt != ST_IDLE);
         done_o <= (state_r == ST_DONE);
         if (state_r == ST_DONE) begin
            enable_output_flag_o <= (err_r == ERR_NONE);
            err_code_o           <= err_r;
            if (is_shift && (err_r == ERR_NONE)) begin
               overflow_flag_o <= ovf_r;
            end
         end
      end
   end

   assign ext_rdata_o = mem_rdata;

endmodule // bit_string_unit

// *** common/bsm_pkg.sv ***
// Shared constants, operation codes and engine states for the bit and string unit
package bsm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Memory geometry
   localparam int         MEM_AW        = 8;
   localparam int         MEM_DEPTH     = 256;
   localparam int         BYTE_W        = 8;
   localparam int         BIT_IDX_W     = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Error codes; every code but ERR_NONE is reported with the enable-output flag cleared
   localparam logic [15:0] ERR_NONE      = 16'h0000;
   localparam logic [15:0] ERR_INDIRECT  = 16'h0006;
   localparam logic [15:0] ERR_RANGE     = 16'h0091;
   localparam logic [15:0] ERR_COUNT     = 16'h0092;
   localparam logic [15:0] ERR_INDEX0    = 16'h009b;

   ////////////////////////////////////////////////////////////////////////////////
   // Limits and field positions
   localparam logic [7:0]  CHAIN_MAX_LEN = 8'h40;
   localparam logic [7:0]  STR_MAX_LEN   = 8'hfe;
   localparam logic [7:0]  FIRST_INDEX   = 8'h01;
   localparam logic [7:0]  ADDR_TOP      = 8'hff;
   localparam logic [2:0]  BIT_LOW       = 3'h0;
   localparam logic [2:0]  BIT_HIGH      = 3'h7;
   localparam int          SIGN_BIT      = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Operations
   typedef enum logic [2:0] {
      OP_SERIAL_BIT_SHIFTER = 3'h0,
      OP_BYTE_SWAP          = 3'h1,
      OP_STRING_LENGTH      = 3'h2,
      OP_STRING_COPY        = 3'h3,
      OP_STRING_APPEND      = 3'h4,
      OP_SUBSTRING_COPY     = 3'h5,
      OP_SUBSTRING_SEARCH   = 3'h6,
      OP_CHARSET_SEARCH     = 3'h7
   } op_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Engine states, one-hot
   typedef enum logic [14:0] {
      ST_IDLE   = 15'h0001,
      ST_RD_A   = 15'h0002,
      ST_RD_B   = 15'h0004,
      ST_RD_C   = 15'h0008,
      ST_CHECK  = 15'h0010,
      ST_SH_RD  = 15'h0020,
      ST_SH_WR  = 15'h0040,
      ST_SW_WR  = 15'h0080,
      ST_CP_RD  = 15'h0100,
      ST_CP_WR  = 15'h0200,
      ST_FIN_WR = 15'h0400,
      ST_CMP_RA = 15'h0800,
      ST_CMP_RB = 15'h1000,
      ST_CMP_EV = 15'h2000,
      ST_DONE   = 15'h4000
   } state_e;

endpackage

// *** rtl/data_mem.sv ***
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
module data_mem
   import bsm_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   input  wire logic              we_i,
   input  wire logic [MEM_AW-1:0] addr_i,
   input  wire logic [BYTE_W-1:0] wdata_i,
   output logic      [BYTE_W-1:0] rdata_o
);

   logic [BYTE_W-1:0] mem_r [MEM_DEPTH];

   // Array has no reset so it maps onto block memory
   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem_r[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= mem_r[addr_i];
      end
   end

endmodule // data_mem

// *** rtl/bit_chain_step.sv ***
// One-position shift of the chain bits that fall inside a single byte
`timescale 1ns/1ps
module bit_chain_step
   import bsm_pkg::*;
(
   input  wire logic [BYTE_W-1:0]    byte_i,
   input  wire logic [BIT_IDX_W-1:0] lo_i,
   input  wire logic [BIT_IDX_W-1:0] hi_i,
   input  wire logic                 minus_i,
   input  wire logic                 carry_i,
   output logic      [BYTE_W-1:0]    byte_o,
   output logic                      carry_o
);

   wire [BYTE_W+1:0] ext_w = {1'b0, byte_i, 1'b0};

   genvar k;
   generate
      for (k = 0; k < BYTE_W; k++) begin : g_bit
         wire in_chain_w = (3'(k) >= lo_i) && (3'(k) <= hi_i);
         wire plus_w     = (3'(k) == lo_i) ? carry_i : ext_w[k];
         wire minus_w    = (3'(k) == hi_i) ? carry_i : ext_w[k+2];
         assign byte_o[k] = in_chain_w ? (minus_i ? minus_w : plus_w) : byte_i[k];
      end
   endgenerate

   // Bit leaving the byte passes to the next byte or to the overflow flag
   assign carry_o = minus_i ? byte_i[lo_i] : byte_i[hi_i];

endmodule // bit_chain_step

// *** tb/bit_string_unit_monitor.sv ***
// Checker for the status outputs of the bit and string unit
`timescale 1ns/1ps
module bit_string_unit_monitor
   import bsm_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        ce_i,
   input wire logic        start_i,
   input wire op_e         op_i,
   input wire logic        ind_fault_i,
   input wire logic [7:0]  chain_len_i,
   input wire logic [7:0]  start_index_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic        enable_output_flag_o,
   input wire logic [15:0] err_code_o,
   input wire logic        overflow_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Latencies assume ce_i stays high for the whole operation
   wire tk = start_i && ce_i && !busy_o && !ind_fault_i;
   wire bad = chain_len_i == 8'h00 || (chain_len_i > CHAIN_MAX_LEN && chain_len_i < 8'hc0);
   ////////////////////////////////////////////////////////////
   property p_busy; start_i && ce_i && !busy_o |=> busy_o; endproperty
   a_busy: assert property (p_busy) else $error("busy not raised");
   property p_ind;
      start_i && ce_i && !busy_o && ind_fault_i |-> ##2 done_o && err_code_o == ERR_INDIRECT;
   endproperty
   a_ind: assert property (p_ind) else $error("indirect fault code wrong");
   property p_cnt;
      tk && op_i == OP_SERIAL_BIT_SHIFTER && bad |-> ##6 done_o && err_code_o == ERR_COUNT;
   endproperty
   a_cnt: assert property (p_cnt) else $error("count field error wrong");
   property p_idx;
      tk && op_i == OP_SUBSTRING_COPY && start_index_i == 8'h00 |-> ##6 err_code_o == ERR_INDEX0;
   endproperty
   a_idx: assert property (p_idx) else $error("zero index code wrong");
   property p_eno; done_o |-> enable_output_flag_o == (err_code_o == ERR_NONE); endproperty
   a_eno: assert property (p_eno) else $error("flag and code disagree");
   property p_hold; !done_o |-> $stable(err_code_o) && $stable(enable_output_flag_o); endproperty
   a_hold: assert property (p_hold) else $error("status moved without done");
   property p_ovf; $changed(overflow_flag_o) |-> done_o && enable_output_flag_o; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow moved off a good op");
   property p_pulse; done_o |=> !done_o; endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   c_shift: cover property (tk && op_i == OP_SERIAL_BIT_SHIFTER ##1 busy_o);
   c_err: cover property (done_o && !enable_output_flag_o);
   c_b2b: cover property (done_o && start_i);
endmodule // bit_string_unit_monitor
bind bit_string_unit bit_string_unit_monitor bit_string_unit_monitor_inst (.*);

// *** tb/tb_top.sv ***
// Self-checking testbench for the bit and string unit
`timescale 1ns/1ps
module tb_top;
   import bsm_pkg::*;
   logic        clk_i = 0, sys_rst_i = 1, start_i = 0, ind_fault_i = 0, data_bit_i = 0;
   logic        ext_we_i = 0, rd_v = 0, rd_p = 0, ovf = 0;
   op_e         op_i = OP_BYTE_SWAP;
   logic [7:0]  addr_a_i = '0, addr_b_i = '0, addr_c_i = '0, chain_len_i = '0, count_i = '0;
   logic [7:0]  start_index_i = '0, ext_addr_i = '0, ext_wdata_i = '0, ext_rdata_o, d;
   logic [2:0]  start_bit_i = '0;
   logic        busy_o, done_o, enable_output_flag_o, overflow_flag_o;
   logic [15:0] err_code_o;
   wire  [17:0] st = {enable_output_flag_o, err_code_o, overflow_flag_o};
   logic [71:0] w;
   logic [17:0] q_op[$];
   logic [7:0]  q_m[$];
   int          n_mismatch = 0, n_compared = 0, m;
   bit_string_unit bit_string_unit_inst (.ce_i(1'h1), .*);
   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [17:0] s, e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic final_report();
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, v);
      ext_we_i = 1;
      rd_v = 0;
      ext_addr_i = a;
      ext_wdata_i = v;
      @(posedge clk_i) #1;
   endtask
   task automatic rd(input logic [7:0] a, e);
      ext_we_i = 0;
      rd_v = 1;
      ext_addr_i = a;
      q_m.push_back(e);
      @(posedge clk_i) #1;
   endtask
   task automatic go(input op_e o, input logic [15:0] e);
      ext_we_i = 0;
      rd_v = 0;
      op_i = o;
      start_i = 1;
      q_op.push_back({e == ERR_NONE, e, ovf});
      @(posedge clk_i) #1 start_i = 0;
      for (int i = 0; i < 3000 && done_o !== 1'h1; i++) @(posedge clk_i) #1;
      if (done_o !== 1'h1) begin
         n_mismatch++;
         final_report();
      end
   endtask
   // Length byte first, then the characters
   task automatic xs(input bit r, input logic [7:0] a, input string t);
      for (int i = -1; i < t.len(); i++) begin
         d = i < 0 ? 8'(t.len()) : t[i];
         if (r) rd(8'(a + 1 + i), d);
         else wr(8'(a + 1 + i), d);
      end
   endtask
   task automatic shift(input int sb, input logic [7:0] n, a);
      logic [15:0] e;
      w = 72'({$urandom, $urandom, $urandom});
      for (int i = 0; i < 9; i++) wr(8'(a + i), w[8*i+:8]);
      m = n[7] ? 256 - n : n;
      d = 8'($urandom);
      data_bit_i = d[0];
      start_bit_i = 3'(sb);
      chain_len_i = n;
      addr_a_i = a;
      e = (m == 0 || m > 64) ? ERR_COUNT : (a + (sb + m - 1) / 8 > 255) ? ERR_RANGE : ERR_NONE;
      if (e == ERR_NONE) begin
         ovf = n[7] ? w[sb] : w[sb+m-1];
         for (int i = 0; i < m - 1; i++)
            if (n[7]) w[sb+i] = w[sb+i+1];
            else w[sb+m-1-i] = w[sb+m-2-i];
         w[n[7] ? sb + m - 1 : sb] = d[0];
      end
      go(OP_SERIAL_BIT_SHIFTER, e);
      for (int i = 0; i < 9; i++) rd(8'(a + i), w[8*i+:8]);
   endtask
   task automatic srch(input op_e o, input logic [7:0] b, s, p, input logic [15:0] e);
      wr(8'h78, s);
      addr_b_i = b;
      go(o, e);
      rd(8'h78, e == ERR_NONE ? p : s);
   endtask
   always @(posedge clk_i) begin
      rd_p <= rd_v;
      #2;
      if (rd_p) chk("ext_rdata", {10'h0, ext_rdata_o}, 18'(q_m.pop_front()));
      if (done_o === 1'h1)
         chk("status", st, q_op.pop_front());
   end
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(61561));
      repeat (8) @(posedge clk_i);
      #1 sys_rst_i = 0;
      shift(4, 8'h0e, 8'h10);
      shift(4, 8'hf2, 8'h10);
      shift(0, 8'h40, 8'h10);
      shift(7, 8'hc0, 8'h10);
      shift(0, 8'h00, 8'h10);
      shift(3, 8'h41, 8'h10);
      shift(3, 8'hbf, 8'h10);
      shift(3, 8'h80, 8'h10);
      shift(4, 8'h0e, 8'hff);
      $display("Test bit chain ended");
      w[15:0] = 16'($urandom);
      wr(8'h30, w[7:0]);
      wr(8'h31, w[15:8]);
      addr_a_i = 8'h30;
      go(OP_BYTE_SWAP, ERR_NONE);
      rd(8'h30, w[15:8]);
      rd(8'h31, w[7:0]);
      addr_a_i = 8'hff;
      go(OP_BYTE_SWAP, ERR_RANGE);
      ind_fault_i = 1;
      for (int k = 0; k < 8; k++) go(op_e'(k), ERR_INDIRECT);
      ind_fault_i = 0;
      $display("Test swap and faults ended");
      xs(0, 8'h40, "abc");
      xs(0, 8'h48, "ca");
      xs(0, 8'h4c, "zc");
      xs(0, 8'h50, "zz");
      addr_a_i = 8'h40;
      addr_b_i = 8'h58;
      go(OP_STRING_LENGTH, ERR_NONE);
      wr(8'hff, 8'h05);
      addr_a_i = 8'hff;
      go(OP_STRING_LENGTH, ERR_RANGE);
      rd(8'h58, 8'h03);
      addr_a_i = 8'h40;
      addr_b_i = 8'h60;
      go(OP_STRING_COPY, ERR_NONE);
      xs(1, 8'h60, "abc");
      go(OP_STRING_APPEND, ERR_NONE);
      xs(1, 8'h60, "abcabc");
      addr_a_i = 8'h60;
      addr_b_i = 8'h70;
      start_index_i = 8'h06;
      count_i = 8'h01;
      go(OP_SUBSTRING_COPY, ERR_NONE);
      count_i = 8'h02;
      go(OP_SUBSTRING_COPY, ERR_RANGE);
      start_index_i = 8'h00;
      go(OP_SUBSTRING_COPY, ERR_INDEX0);
      xs(1, 8'h70, "c");
      addr_c_i = 8'h78;
      srch(OP_SUBSTRING_SEARCH, 8'h48, 8'h01, 8'h03, ERR_NONE);
      srch(OP_SUBSTRING_SEARCH, 8'h48, 8'h04, 8'h00, ERR_NONE);
      srch(OP_SUBSTRING_SEARCH, 8'h48, 8'h00, 8'h00, ERR_INDEX0);
      srch(OP_CHARSET_SEARCH, 8'h4c, 8'h04, 8'h06, ERR_NONE);
      srch(OP_CHARSET_SEARCH, 8'h50, 8'h01, 8'h00, ERR_NONE);
      srch(OP_CHARSET_SEARCH, 8'h4c, 8'h07, 8'h00, ERR_RANGE);
      rd_v = 0;
      $display("Test strings ended");
      repeat (3) @(posedge clk_i);
      final_report();
   end
endmodule // tb_top
